//--- core/dmc_ctrl.sv
`timescale 1ns/1ps
module dmc_ctrl
  import dmc_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // axi4-lite slave
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [3:0]  s_axi_araddr_i,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  // link
  dmc_link_if.ctl          link
);
  import dmc_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b10
  } dmc_st_e;

  typedef struct packed {
    dmc_st_e     st;
    dmc_op_e     op;
    logic [3:0]  idx;
    logic [9:0]  cnt;
    dmc_dev_e    dev;
    logic        dll_on;
    logic        err;
    logic [13:0] mr0;
    logic [7:0]  lat;
    logic [7:0]  lcnt;
    logic        lrun;
    logic        cke;
    logic        ck_fast;
    logic [3:0]  cmd;
    logic [2:0]  ba;
    logic [13:0] addr;
    logic        awf;
    logic [3:0]  awa;
    logic        wf;
    logic [31:0] wd;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
  } dmc_ctrl_s;

  dmc_ctrl_s s_q, s_d;
  dmc_step_s stp;

  function automatic dmc_step_s mk(input dmc_act_e a, input logic [2:0] b,
                                   input logic [13:0] g, input int w);
    mk = '{act: a, ba: b, arg: g, wt: 10'(w)};
  endfunction

  // fixed sequences per operation; odt stays low throughout
  function automatic dmc_step_s step_f(input dmc_op_e op,
                                       input logic [3:0] i,
                                       input logic [13:0] mr0);
    logic [13:0] rst;
    rst    = mr0 | (14'h0001 << MR0_RST_BIT);
    step_f = mk(A_END, BA_MR0, '0, 0);
    case (op)
      OP_REF: case (i)
        4'h0: step_f = mk(A_PREA, BA_MR0, '0, T_RP_CK);
        4'h1: step_f = mk(A_REF, BA_MR0, '0, T_RFC_CK);
        default: ;
      endcase
      OP_SRE: if (i == 4'h0) step_f = mk(A_SRE, BA_MR0, '0, T_CKSRE_CK);
      OP_SRX: case (i)
        4'h0: step_f = mk(A_SRX, BA_MR0, '0, T_XS_CK);
        4'h1: step_f = mk(A_WAIT, BA_MR0, '0, T_VREF_CK);
        default: ;
      endcase
      OP_DLL_OFF: case (i)
        4'h0: step_f = mk(A_MRS, BA_MR1, MR1_DLL_OFF, T_MOD_CK);
        4'h1: step_f = mk(A_SRE, BA_MR0, '0, T_CKSRE_CK);
        4'h2: step_f = mk(A_CKLO, BA_MR0, '0, T_CKSRX_CK);
        4'h3: step_f = mk(A_SRX, BA_MR0, '0, T_XS_CK);
        4'h4: step_f = mk(A_MRS, BA_MR0, MR0_CL6, T_MRD_CK);
        4'h5: step_f = mk(A_MRS, BA_MR2, MR2_CWL6, T_MOD_CK);
        4'h6: step_f = mk(A_ZQ, BA_MR0, '0, T_ZQOPER_CK);
        default: ;
      endcase
      OP_DLL_ON: case (i)
        4'h0: step_f = mk(A_SRE, BA_MR0, '0, T_CKSRE_CK);
        4'h1: step_f = mk(A_CKHI, BA_MR0, '0, T_CKSRX_CK);
        4'h2: step_f = mk(A_SRX, BA_MR0, '0, T_XS_CK);
        4'h3: step_f = mk(A_MRS, BA_MR1, '0, T_MRD_CK);
        4'h4: step_f = mk(A_MRS, BA_MR0, rst, T_MRD_CK);
        4'h5: step_f = mk(A_MRS, BA_MR2, '0, T_MOD_CK);
        4'h6: step_f = mk(A_WAIT, BA_MR0, '0, T_DLLK_CK);
        4'h7: step_f = mk(A_ZQ, BA_MR0, '0, T_ZQOPER_CK);
        default: ;
      endcase
      OP_PD_FCHG: case (i)
        4'h0: step_f = mk(A_PDE, BA_MR0, '0, T_CKSRE_CK);
        4'h1: step_f = mk(A_WAIT, BA_MR0, '0, T_CKSRX_CK);
        4'h2: step_f = mk(A_PDX, BA_MR0, '0, T_XP_CK);
        4'h3: step_f = mk(A_MRS, BA_MR0, rst, T_MOD_CK);
        4'h4: step_f = mk(A_WAIT, BA_MR0, '0, T_DLLK_CK);
        default: ;
      endcase
      OP_READ: if (i == 4'h0) step_f = mk(A_RD, BA_MR0, '0, 1);
      default: ;
    endcase
  endfunction

  function automatic logic legal_f(input dmc_op_e op, input dmc_dev_e d,
                                   input logic dll);
    case (op)
      OP_SRX:     legal_f = (d == DEV_SR);
      OP_DLL_OFF: legal_f = (d == DEV_IDLE) && dll;
      OP_DLL_ON:  legal_f = (d == DEV_IDLE) && !dll;
      OP_NONE:    legal_f = 1'b0;
      default:    legal_f = (d == DEV_IDLE);
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    stp = step_f(s_q.op, s_q.idx, s_q.mr0);
    s_d.cmd = C_NOP;
    // read strobe capture, counted in controller cycles
    if (s_q.lrun) begin
      s_d.lcnt = s_q.lcnt + 8'd1;
      if (link.dqs) begin
        s_d.lat  = s_q.lcnt;
        s_d.lrun = 1'b0;
      end
    end
    case (s_q.st)
      S_ISSUE: begin
        s_d.cnt = stp.wt;
        s_d.st  = S_WAIT;
        s_d.ba  = stp.ba;
        s_d.addr = stp.arg;
        case (stp.act)
          A_END: s_d.st = S_IDLE;
          A_PREA: begin
            s_d.cmd = C_PRE;
            s_d.addr = 14'h0001 << A10_BIT;
          end
          A_REF: s_d.cmd = C_REF;
          A_MRS: begin
            s_d.cmd = C_MRS;
            if (stp.ba == BA_MR1) begin
              s_d.dll_on = !stp.arg[MR1_DLL_BIT];
            end
          end
          A_SRE: begin
            s_d.cmd = C_REF;
            s_d.cke = 1'b0;
            s_d.dev = DEV_SR;
          end
          A_PDE: begin
            s_d.cke = 1'b0;
            s_d.dev = DEV_PD;
          end
          A_SRX, A_PDX: begin
            s_d.cke = 1'b1;
            s_d.dev = DEV_IDLE;
          end
          // rate gap is crossed only here, inside self-refresh
          A_CKLO: s_d.ck_fast = 1'b0;
          A_CKHI: s_d.ck_fast = 1'b1;
          A_ZQ: begin
            s_d.cmd = C_ZQ;
            s_d.addr = 14'h0001 << A10_BIT;
          end
          A_RD: begin
            s_d.cmd  = C_RD;
            s_d.lrun = 1'b1;
            s_d.lcnt = 8'h00;
          end
          default: ;
        endcase
      end
      S_WAIT: begin
        if (s_q.cnt <= 10'd1) begin
          s_d.idx = s_q.idx + 4'd1;
          s_d.st  = S_ISSUE;
        end else begin
          s_d.cnt = s_q.cnt - 10'd1;
        end
      end
      default: ;
    endcase
    // axi write channels, taken in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_d.awf = 1'b1;
      s_d.awa = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_d.wf = 1'b1;
      s_d.wd = s_axi_wdata_i;
    end
    if (s_q.bv && s_axi_bready_i) s_d.bv = 1'b0;
    if (s_q.awf && s_q.wf) begin
      s_d.awf = 1'b0;
      s_d.wf  = 1'b0;
      s_d.bv  = 1'b1;
      s_d.br  = RESP_OK;
      case ({s_q.awa[3:2], 2'b00})
        REG_CMD: begin
          if (s_q.wd[2:0] != OP_NONE) begin
            if (s_q.st == S_IDLE &&
                legal_f(dmc_op_e'(s_q.wd[2:0]), s_q.dev, s_q.dll_on)) begin
              s_d.op  = dmc_op_e'(s_q.wd[2:0]);
              s_d.idx = '0;
              s_d.st  = S_ISSUE;
            end else begin
              s_d.err = 1'b1;
            end
          end
        end
        REG_STAT: begin
          if (s_q.wd[STAT_ERR_BIT] && !s_d.err) s_d.err = 1'b0;
          else if (s_q.wd[STAT_ERR_BIT]) s_d.err = s_d.err & ~s_q.err;
        end
        REG_CFG: s_d.mr0 = s_q.wd[13:0];
        default: s_d.br = RESP_DEC;
      endcase
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_d.rv = 1'b1;
      s_d.rr = RESP_OK;
      case ({s_axi_araddr_i[3:2], 2'b00})
        REG_CMD:  s_d.rd = {29'h0, s_q.op};
        // busy spans the strobe wait, so the latency is fresh once idle
        REG_STAT: s_d.rd = {16'h0, s_q.lat, 3'h0, s_q.err, s_q.dll_on,
                            s_q.dev, (s_q.st != S_IDLE) || s_q.lrun};
        REG_CFG:  s_d.rd = {18'h0, s_q.mr0};
        default: begin
          s_d.rd = '0;
          s_d.rr = RESP_DEC;
        end
      endcase
    end else if (s_q.rv && s_axi_rready_i) begin
      s_d.rv = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q         <= '0;
      s_q.dll_on  <= 1'b1;
      s_q.cke     <= 1'b1;
      s_q.ck_fast <= 1'b1;
      s_q.cmd     <= C_NOP;
      s_q.mr0     <= MR0_CL6;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o = !s_q.awf && !s_q.bv;
  assign s_axi_wready_o  = !s_q.wf && !s_q.bv;
  assign s_axi_bvalid_o  = s_q.bv;
  assign s_axi_bresp_o   = s_q.br;
  assign s_axi_arready_o = !s_q.rv;
  assign s_axi_rvalid_o  = s_q.rv;
  assign s_axi_rdata_o   = s_q.rd;
  assign s_axi_rresp_o   = s_q.rr;
  assign link.cke     = s_q.cke;
  assign link.cs_n    = s_q.cmd[3];
  assign link.ras_n   = s_q.cmd[2];
  assign link.cas_n   = s_q.cmd[1];
  assign link.we_n    = s_q.cmd[0];
  assign link.odt     = 1'b0;
  assign link.ck_fast = s_q.ck_fast;
  assign link.ba      = s_q.ba;
  assign link.addr    = s_q.addr;
endmodule // dmc_ctrl

//--- core/dmc_pkg.sv
package dmc_pkg;
  localparam int CLK_NS = 50;
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  // timing figures; plain defaults
  localparam int T_RFC_NS    = 110;
  localparam int T_RP_NS     = 15;
  localparam int T_CKSRE_NS  = 10;
  localparam int T_CKSRX_NS  = 10;
  localparam int T_XS_NS     = 120;
  localparam int T_XP_NS     = 24;
  localparam int T_MOD_CK    = 12;
  localparam int T_MRD_CK    = 4;
  localparam int T_DLLK_CK   = 512;
  localparam int T_ZQOPER_CK = 512;
  localparam int T_VREF_CK   = 512;
  localparam int T_RFC_CK    = cyc_min(T_RFC_NS);
  localparam int T_RP_CK     = cyc_min(T_RP_NS);
  localparam int T_CKSRE_CK  = cyc_min(T_CKSRE_NS);
  localparam int T_CKSRX_CK  = cyc_min(T_CKSRX_NS);
  localparam int T_XS_CK     = cyc_min(T_XS_NS);
  localparam int T_XP_CK     = cyc_min(T_XP_NS);
  // command pins {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] C_MRS = 4'h0;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_ZQ  = 4'h6;
  localparam logic [3:0] C_NOP = 4'h7;
  // mode register fields
  localparam int A10_BIT      = 10;
  localparam int MR1_DLL_BIT  = 0;
  localparam int MR0_RST_BIT  = 8;
  localparam int MR0_CL_LO    = 4;
  localparam int CL_BASE      = 4;
  localparam int CL_DLL_OFF   = 6;
  localparam logic [13:0] MR0_CL6     = 14'h0020;
  localparam logic [13:0] MR2_CWL6    = 14'h0008;
  localparam logic [13:0] MR1_DLL_OFF = 14'h0001;
  localparam logic [13:0] MR1_RTT_MSK = 14'h0244;
  localparam logic [13:0] MR2_RTT_MSK = 14'h0600;
  localparam logic [2:0]  BA_MR0 = 3'h0;
  localparam logic [2:0]  BA_MR1 = 3'h1;
  localparam logic [2:0]  BA_MR2 = 3'h2;
  // controller registers
  localparam logic [3:0] REG_CMD  = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CFG  = 4'h8;
  localparam int STAT_ERR_BIT = 4;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_REF = 3'b001, OP_SRE = 3'b010,
    OP_SRX  = 3'b011, OP_DLL_OFF = 3'b100, OP_DLL_ON = 3'b101,
    OP_PD_FCHG = 3'b110, OP_READ = 3'b111
  } dmc_op_e;
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00, DEV_SR = 2'b01, DEV_PD = 2'b10
  } dmc_dev_e;
  typedef enum logic [3:0] {
    A_END = 4'h0, A_PREA = 4'h1, A_REF = 4'h2, A_MRS = 4'h3,
    A_SRE = 4'h4, A_SRX = 4'h5, A_PDE = 4'h6, A_PDX = 4'h7,
    A_CKLO = 4'h8, A_CKHI = 4'h9, A_ZQ = 4'hA, A_RD = 4'hB,
    A_WAIT = 4'hC
  } dmc_act_e;
  typedef struct packed {
    dmc_act_e    act;
    logic [2:0]  ba;
    logic [13:0] arg;
    logic [9:0]  wt;
  } dmc_step_s;
endpackage

//--- core/dmc_link_if.sv
`timescale 1ns/1ps
interface dmc_link_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        odt;
  logic        ck_fast;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic        dqs;
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, odt, ck_fast,
               output ba, addr, input dqs);
  modport dram (input cke, cs_n, ras_n, cas_n, we_n, odt, ck_fast,
                input ba, addr, output dqs);
endinterface

//--- core/dmc_dram.sv
`timescale 1ns/1ps
module dmc_dram
  import dmc_pkg::*;
#(
  parameter int AL = 0
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  // link
  dmc_link_if.dram  link,
  // status
  input  wire logic viol_clr_i,
  output logic      viol_o,
  output logic      dll_on_o,
  output logic      self_refresh_o,
  output logic      power_down_o
);
  import dmc_pkg::*;

  typedef struct packed {
    dmc_dev_e    st;
    logic        dll_on;
    logic [2:0]  cl_fld;
    logic        cke_p;
    logic        ck_p;
    logic [9:0]  rfc;
    logic [9:0]  vref;
    logic [4:0]  rcnt;
    logic        rrun;
    logic        dqs;
    logic        viol;
  } dmc_dram_s;

  dmc_dram_s s_q, s_d;
  logic [3:0] cmd;
  logic [4:0] lat;
  logic       bad;

  assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};

  always_comb begin
    s_d   = s_q;
    bad   = 1'b0;
    // dll off forces cl six; strobe lands one cycle early
    if (s_q.dll_on) begin
      lat = 5'(AL + CL_BASE) + 5'(s_q.cl_fld);
    end else begin
      lat = 5'(AL + CL_DLL_OFF - 1);
    end
    s_d.cke_p = link.cke;
    s_d.ck_p  = link.ck_fast;
    s_d.dqs   = 1'b0;
    if (s_q.rfc != '0) s_d.rfc = s_q.rfc - 10'd1;
    if (s_q.vref != '0) s_d.vref = s_q.vref - 10'd1;
    if (s_q.rrun) begin
      s_d.rcnt = s_q.rcnt - 5'd1;
      if (s_q.rcnt == 5'd1) begin
        s_d.dqs  = 1'b1;
        s_d.rrun = 1'b0;
      end
    end
    case (s_q.st)
      DEV_SR: begin
        // pins other than cke ignored; contents kept internally
        if (link.cke) begin
          s_d.st   = DEV_IDLE;
          s_d.vref = 10'(T_VREF_CK);
        end
      end
      DEV_PD: begin
        if (link.cke) s_d.st = DEV_IDLE;
        if (link.odt) bad = 1'b1;
      end
      default: begin
        if (link.ck_fast != s_q.ck_p) bad = 1'b1;
        if (!link.cs_n && s_q.rfc != '0 && cmd != C_NOP) begin
          bad = 1'b1;
        end
        if (!link.cke && !s_q.cke_p && !link.cs_n &&
            (cmd == C_PRE || cmd == C_ACT || cmd == C_REF)) begin
          bad = 1'b1;
        end
        if (!s_q.dll_on && link.odt) bad = 1'b1;
        if (!link.cke && s_q.cke_p) begin
          if (!link.cs_n && cmd == C_REF) s_d.st = DEV_SR;
          else s_d.st = DEV_PD;
        end else if (link.cke && !link.cs_n) begin
          case (cmd)
            C_REF: s_d.rfc = 10'(T_RFC_CK);
            C_MRS: begin
              if (link.ba == BA_MR1) begin
                s_d.dll_on = !link.addr[MR1_DLL_BIT];
                if (link.addr[MR1_DLL_BIT] &&
                    (link.addr & MR1_RTT_MSK) != '0) bad = 1'b1;
              end
              if (link.ba == BA_MR0) begin
                s_d.cl_fld = link.addr[MR0_CL_LO +: 3];
              end
              if (link.ba == BA_MR2 && !s_q.dll_on &&
                  (link.addr & MR2_RTT_MSK) != '0) bad = 1'b1;
            end
            C_WR: if (s_q.vref != '0) bad = 1'b1;
            C_RD: begin
              s_d.rrun = 1'b1;
              s_d.rcnt = lat - 5'd1;
            end
            default: ;
          endcase
        end
      end
    endcase
    if (viol_clr_i) s_d.viol = 1'b0;
    if (bad) s_d.viol = 1'b1;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q        <= '0;
      s_q.dll_on <= 1'b1;
      s_q.cke_p  <= 1'b1;
      s_q.ck_p   <= 1'b1;
      s_q.cl_fld <= 3'h2;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.dqs       = s_q.dqs;
  assign viol_o         = s_q.viol;
  assign dll_on_o       = s_q.dll_on;
  assign self_refresh_o = (s_q.st == DEV_SR);
  assign power_down_o   = (s_q.st == DEV_PD);
endmodule // dmc_dram

//--- tb/dmc_link_monitor.sv
`timescale 1ns/1ps
module dmc_link_monitor
  import dmc_pkg::*;
(
  // clock and reset
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  // link signals
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        odt,
  input wire logic        ck_fast,
  input wire logic [2:0]  ba,
  input wire logic [13:0] addr,
  input wire logic        dqs
);
  logic [3:0] cmd;
  logic       dll_off_q;
  logic       cke_q;
  logic [3:0] cl_q;
  int         xit_q;
  int         lock_q;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // strobe figures below assume additive latency zero
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dll_off_q <= 1'b0;
      cke_q     <= 1'b1;
      cl_q      <= 4'h6;
      xit_q     <= T_VREF_CK;
      lock_q    <= T_DLLK_CK;
    end else begin
      cke_q <= cke;
      if (cmd == C_MRS && ba == BA_MR1) dll_off_q <= addr[MR1_DLL_BIT];
      if (cmd == C_MRS && ba == BA_MR0)
        cl_q <= {1'b0, addr[MR0_CL_LO +: 3]} + 4'(CL_BASE);
      if (cke && !cke_q) xit_q <= 0;
      else if (xit_q < T_VREF_CK) xit_q <= xit_q + 1;
      if (cmd == C_MRS && ba == BA_MR0 && addr[MR0_RST_BIT]) lock_q <= 0;
      else if (lock_q < T_DLLK_CK) lock_q <= lock_q + 1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence mr1_off_s;
    cmd == C_MRS && ba == BA_MR1 && addr[MR1_DLL_BIT];
  endsequence
  sequence mr1_on_s;
    cmd == C_MRS && ba == BA_MR1 && !addr[MR1_DLL_BIT] && dll_off_q;
  endsequence
  sequence sre_s;
    cmd == C_REF && !cke;
  endsequence
  sequence dll_rst_s;
    cmd == C_MRS && ba == BA_MR0 && addr[MR0_RST_BIT];
  endsequence
  refresh_quiet_a: assert property (
    cmd == C_REF |=> (cmd == C_NOP)[*2])
    else $error("command inside refresh gap");
  cke_cmd_a: assert property (
    (cmd == C_PRE || cmd == C_ACT || cmd == C_REF) |-> $past(cke))
    else $error("row command with clock enable low");
  pre_all_a: assert property (cmd == C_PRE |-> addr[A10_BIT])
    else $error("precharge without all-bank bit");
  write_vref_a: assert property (cmd == C_WR |-> xit_q >= T_VREF_CK)
    else $error("write too soon after exit");
  mr1_off_a: assert property (
    mr1_off_s |-> (addr & MR1_RTT_MSK) == 14'h0)
    else $error("dll off with termination set");
  mr_dll_off_a: assert property (cmd == C_MRS && dll_off_q |->
    (ba != BA_MR0 || addr[6:4] == 3'h2) && (ba != BA_MR2 ||
    (addr[5:3] == 3'h1 && (addr & MR2_RTT_MSK) == 14'h0)))
    else $error("latency or termination wrong with dll off");
  rd_off_a: assert property (cmd == C_RD && dll_off_q |=>
    (!dqs)[*4] ##1 dqs)
    else $error("strobe timing wrong with dll off");
  rd_on_a: assert property (
    cmd == C_RD && !dll_off_q && cl_q == 4'h6 |=>
    (!dqs)[*5] ##1 dqs)
    else $error("strobe timing wrong with dll on");
  ck_change_a: assert property (
    !$stable(ck_fast) |-> !cke && !$past(cke))
    else $error("clock rate changed while active");
  ck_exit_a: assert property ($rose(cke) |-> $stable(ck_fast))
    else $error("clock not stable at exit");
  odt_off_a: assert property (dll_off_q || !cke |-> !odt)
    else $error("termination on while forbidden");
  dll_off_seq_a: assert property (mr1_off_s |-> ##[12:40] sre_s)
    else $error("self-refresh missing after dll off");
  dll_on_seq_a: assert property (mr1_on_s |-> ##[4:40] dll_rst_s)
    else $error("dll reset missing after dll on");
  lock_a: assert property (cmd == C_RD |-> lock_q >= T_DLLK_CK)
    else $error("read before dll lock");
endmodule // dmc_link_monitor

//--- tb/dmc_tb_top.sv
`timescale 1ns/1ps
module dmc_tb_top;
  import dmc_pkg::*;
  localparam int AL = 0;
  logic clock_i, reset_n_i, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid;
  logic viol_clr, viol, dll_on, sr, pd;
  int miscompares, comparisons, seed, dev, dll, err, cl, lat, lat_ok, fld;
  int ops[14] = '{7, 0, 1, 3, 5, 6, 4, 7, 4, 2, 1, 3, 5, 7};
  dmc_link_if link_if();
  dmc_ctrl dmc_ctrl_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .link(link_if));
  dmc_dram #(.AL(AL)) dmc_dram_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .link(link_if), .viol_clr_i(viol_clr), .viol_o(viol),
    .dll_on_o(dll_on), .self_refresh_o(sr), .power_down_o(pd));
  dmc_link_monitor dmc_link_monitor_i (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .cke(link_if.cke), .cs_n(link_if.cs_n),
    .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
    .odt(link_if.odt), .ck_fast(link_if.ck_fast), .ba(link_if.ba),
    .addr(link_if.addr), .dqs(link_if.dqs));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_up;
    miscompares++;
    $display("mismatch bus wait expected answer seen none");
    report_and_stop;
  endtask
  // bready is offered early; the answer comes two edges after both halves
  task axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] o);
    int n;
    logic aw_ok, w_ok, b_ok;
    n = 0;
    aw_ok = 0;
    w_ok = 0;
    b_ok = 0;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(posedge clock_i);
      n++;
      if (n > 200) give_up;
      if (!aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        o = bresp;
        b_ok = 1;
        bready <= 1'b0;
      end
    end
  endtask
  task axi_rd(input logic [3:0] a, output logic [31:0] v,
              output logic [1:0] o);
    int n;
    logic a_ok, r_ok;
    n = 0;
    a_ok = 0;
    r_ok = 0;
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok) begin
      @(posedge clock_i);
      n++;
      if (n > 200) give_up;
      if (!a_ok && arready) begin
        a_ok = 1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        v = rdata;
        o = rresp;
        r_ok = 1;
        rready <= 1'b0;
      end
    end
  endtask
  task check_stat;
    logic [31:0] m, e;
    m = lat_ok ? 32'h0000FF1F : 32'h0000001F;
    e = {16'h0, 8'(lat), 3'h0, 1'(err), 1'(dll), 2'(dev), 1'b0};
    axi_rd(REG_STAT, d, r);
    check("status", d & m, e & m);
    check("violation", {31'h0, viol}, 32'h0);
    check("dll flag", {31'h0, dll_on}, 32'(dll));
    check("self-refresh", {31'h0, sr}, 32'(dev == 1));
    check("power-down", {31'h0, pd}, 32'h0);
  endtask
  task run_op(input int op);
    int n;
    bit ok;
    ok = (op == 3) ? dev == 1 : (op == 4) ? dev == 0 && dll == 1 :
         (op == 5) ? dev == 0 && dll == 0 : dev == 0;
    axi_wr(REG_CMD, 32'(op), r);
    check("command response", {30'h0, r}, {30'h0, RESP_OK});
    n = 0;
    d = 32'h1;
    while (d[0] !== 1'b0) begin
      n++;
      if (n > 3000) give_up;
      axi_rd(REG_STAT, d, r);
    end
    if (!ok) err = 1;
    else if (op == 2) dev = 1;
    else if (op == 3) dev = 0;
    else if (op == 4) dll = 0;
    else if (op == 5 || op == 6) cl = fld + CL_BASE;
    // dll off forces latency six and moves the strobe a cycle early
    if (ok && op == 4) cl = CL_DLL_OFF;
    if (ok && op == 5) dll = 1;
    if (ok && op == 7) lat = dll ? AL + cl : AL + cl - 1;
    if (ok && op == 7) lat_ok = 1;
    check_stat;
    if (err) begin
      axi_wr(REG_STAT, 32'h10, r);
      err = 0;
      check_stat;
    end
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, viol_clr} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    reset_n_i = 1'b0;
    seed = 98;
    {dev, err, lat, lat_ok, miscompares, comparisons} = '0;
    dll = 1;
    cl = 6;
    fld = 2;
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1'b1;
    axi_rd(REG_CFG, d, r);
    check("config reset", d, 32'h20);
    axi_rd(4'hC, d, r);
    check("unmapped read", {30'h0, r}, {30'h0, RESP_DEC});
    check("unmapped data", d, 32'h0);
    axi_wr(4'hC, 32'h5A, r);
    check("unmapped write", {30'h0, r}, {30'h0, RESP_DEC});
    foreach (ops[i]) run_op(ops[i]);
    repeat (3) begin
      fld = 1 + ($unsigned($random(seed)) % 7);
      axi_wr(REG_CFG, 32'(fld) << 4, r);
      axi_rd(REG_CFG, d, r);
      check("config", d, 32'(fld) << 4);
      run_op(6);
      run_op(7);
    end
    axi_rd(REG_CMD, d, r);
    check("last command", d, 32'h7);
    report_and_stop;
  end
endmodule // dmc_tb_top
